// File: pkg/snc_ext_if.sv
`timescale 1ns/1ps
// synchronised parallel command strobes
interface snc_ext_if;
   logic enter_p;
   logic cancel_p;
   logic up_p;
   logic down_p;
   logic preset_p;
   modport src (output enter_p, cancel_p, up_p, down_p, preset_p);
   modport dst (input enter_p, cancel_p, up_p, down_p, preset_p);
endinterface

// File: pkg/snc_pkg.sv
package snc_pkg;
   // character and digit widths
   localparam int CHAR_W = 8;
   localparam int MAX_CHARS = 32;
   localparam int POS_W = 5;
   localparam int MAX_DIGITS = 6;
   localparam int CNT_DIG_W = 3;
   localparam int VAL_W = 20;
   localparam int OUT_CNT_W = 16;
   localparam int NUM_OUTS = 8;
   localparam logic [CHAR_W-1:0] ASCII_ZERO = 8'h30;
   localparam logic [CHAR_W-1:0] ASCII_NINE = 8'h39;
   localparam logic [VAL_W-1:0] MAX_VALUE = 20'hf423f;
   localparam logic [VAL_W-1:0] RESET_VALUE = 20'h00000;
   localparam logic [OUT_CNT_W-1:0] CNT_RESET = 16'h0000;
   // output bit positions
   localparam int OUT_OK_BIT = 0;
   localparam int OUT_NG_BIT = 1;
   // checker states
   typedef enum logic [1:0] {
      SNC_EMPTY,
      SNC_RUN,
      SNC_ERR
   } snc_state_t;
   typedef logic [CHAR_W-1:0] snc_char_t;
endpackage

// File: rtl/snc_checker.sv
`timescale 1ns/1ps
module snc_checker
   import snc_pkg::*;
#(
   parameter int NCHARS = snc_pkg::MAX_CHARS
) (
   input wire logic clk_i, // system clock
   input wire logic rst_n_i, // async reset, active low
   input wire logic read_valid_i, // one-cycle read strobe
   input wire logic [NCHARS*snc_pkg::CHAR_W-1:0] read_data_i, // chars, index 0 first
   input wire logic [snc_pkg::POS_W:0] read_len_i, // chars in read
   input wire logic dir_reverse_i, // count from tail
   input wire logic [snc_pkg::POS_W-1:0] start_digit_i, // 1-based start
   input wire logic [snc_pkg::CNT_DIG_W-1:0] eff_digits_i, // 1..6
   input wire logic signed [7:0] increment_i, // signed step
   input wire logic clear_key_i, // clear key pulse
   input wire logic [4:0] ext_pins_i, // async external inputs
   output logic [snc_pkg::NUM_OUTS-1:0] outputs_o, // parallel outputs, pulse
   output logic error_o, // error indicator
   output logic show_read_o, // display shows read
   output logic [snc_pkg::VAL_W-1:0] disp_value_o, // upper line value
   output logic [snc_pkg::OUT_CNT_W-1:0] disp_count_o, // lower line counter
   output logic seq_empty_o // sequence empty
);
   import snc_pkg::*;

   snc_ext_if ext ();
   snc_state_t state;
   logic [VAL_W-1:0] expected;
   logic [VAL_W-1:0] start_val;
   logic [OUT_CNT_W-1:0] count;
   logic [NUM_OUTS-1:0] outs;
   logic error;
   logic show_read;
   logic [VAL_W-1:0] disp_value;
   logic seq_empty;

   snc_ext_sync u_sync (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .pins_i(ext_pins_i),
      .ext(ext.src)
   );

   // power of ten for a digit count
   function automatic logic [VAL_W:0] pow10(input logic [CNT_DIG_W-1:0] n);
      case (n)
         3'd1: pow10 = 21'd10;
         3'd2: pow10 = 21'd100;
         3'd3: pow10 = 21'd1000;
         3'd4: pow10 = 21'd10000;
         3'd5: pow10 = 21'd100000;
         default: pow10 = 21'd1000000;
      endcase
   endfunction

   // step value by signed increment modulo 10^n
   function automatic logic [VAL_W-1:0] step(input logic [VAL_W-1:0] v,
                                              input logic signed [8:0] d,
                                              input logic [CNT_DIG_W-1:0] n);
      logic signed [22:0] s;
      logic signed [22:0] m;
      s = 23'(signed'({3'b000, v})) + 23'(d);
      m = signed'({2'b00, pow10(n)});
      // full modulo: a step of up to 128 can pass 10 or 100 more than once
      s = s % m;
      if (s < 0) s = s + m;
      step = s[VAL_W-1:0];
   endfunction

   // character index of each target digit
   logic [MAX_DIGITS-1:0] dig_ok;
   logic [3:0] dig_val [MAX_DIGITS];
   genvar gi;
   generate
      for (gi = 0; gi < MAX_DIGITS; gi++) begin : g_dig
         wire [POS_W+1:0] base = {2'b00, start_digit_i} - 7'd1;
         // forward: start-1+k ; reverse: len-start-(n-1-k)
         wire [POS_W+1:0] fwd = base + 7'(gi);
         wire [POS_W+1:0] rev = {1'b0, read_len_i} - {2'b00, start_digit_i}
                                - 7'(eff_digits_i) + 7'd1 + 7'(gi);
         wire [POS_W+1:0] idx = dir_reverse_i ? rev : fwd;
         wire in_rng = (idx < {1'b0, read_len_i});
         wire [CHAR_W-1:0] ch = read_data_i[idx[POS_W-1:0]*CHAR_W +: CHAR_W];
         wire used = (gi < eff_digits_i);
         assign dig_ok[gi] = !used || (in_rng && ch >= ASCII_ZERO && ch <= ASCII_NINE);
         assign dig_val[gi] = used ? 4'(ch - ASCII_ZERO) : 4'h0;
      end
   endgenerate

   // decimal assembly, up to six digits
   logic [VAL_W-1:0] read_num;
   always_comb begin
      read_num = '0;
      for (int k = 0; k < MAX_DIGITS; k++) begin
         if (k < eff_digits_i) read_num = VAL_W'(read_num * 10 + dig_val[k]);
      end
   end

   wire digits_ok = &dig_ok && eff_digits_i != 3'd0 && eff_digits_i <= 3'(MAX_DIGITS);
   wire is_empty = (state == SNC_EMPTY);
   wire match = digits_ok && !is_empty && read_num == expected;
   wire rd_ok = read_valid_i && (match || (is_empty && digits_ok));
   wire rd_ng = read_valid_i && !rd_ok;
   wire do_ok = rd_ok || (ext.enter_p && !is_empty);
   wire signed [8:0] inc = 9'(increment_i);
   wire [VAL_W-1:0] exp_up = step(expected, inc, eff_digits_i);
   wire [VAL_W-1:0] exp_dn = step(expected, -inc, eff_digits_i);
   wire [VAL_W-1:0] first_next = step(read_num, inc, eff_digits_i);

   // expected-value pipeline and sequence state
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state <= SNC_EMPTY;
         seq_empty <= 1'b1;
         expected <= RESET_VALUE;
         start_val <= RESET_VALUE;
      end else if (ext.preset_p) begin
         state <= SNC_EMPTY;
         seq_empty <= 1'b1;
      end else if (read_valid_i) begin
         if (rd_ok && is_empty) begin
            start_val <= read_num;
            expected <= first_next;
            state <= SNC_RUN;
            seq_empty <= 1'b0;
         end else if (rd_ok) begin
            expected <= exp_up;
            state <= SNC_RUN;
         end else if (!is_empty) begin
            state <= SNC_ERR;
         end
      end else if (!is_empty) begin
         if (ext.enter_p) expected <= exp_up;
         else if (ext.up_p) expected <= exp_up;
         else if (ext.down_p) expected <= exp_dn;
         else if (ext.cancel_p) expected <= step(start_val, 9'sd0, eff_digits_i);
         if (clear_key_i && state == SNC_ERR) state <= SNC_RUN;
      end
   end

   // results, counter and display
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         outs <= '0;
         count <= CNT_RESET;
         error <= 1'b0;
         show_read <= 1'b0;
         disp_value <= RESET_VALUE;
      end else begin
         // only OK and NG ever set
         outs <= '0;
         outs[OUT_OK_BIT] <= do_ok && !ext.preset_p;
         outs[OUT_NG_BIT] <= rd_ng && !ext.preset_p;
         if ((read_valid_i || ext.enter_p) && !ext.preset_p && !(ext.enter_p && is_empty
             && !read_valid_i))
            count <= OUT_CNT_W'(count + 1'b1);
         if (ext.preset_p) begin
            error <= 1'b0;
            show_read <= 1'b0;
         end else if (rd_ng && !is_empty) begin
            error <= 1'b1;
            show_read <= 1'b1;
            disp_value <= read_num;
         end else if (do_ok) begin
            error <= 1'b0;
            show_read <= 1'b0;
            disp_value <= is_empty ? first_next : exp_up;
         end else if (clear_key_i && error) begin
            error <= 1'b0;
            show_read <= 1'b0;
            disp_value <= expected;
         end else if (!read_valid_i && !is_empty && !show_read) begin
            disp_value <= expected;
         end
      end
   end

   assign outputs_o = outs;
   assign error_o = error;
   assign show_read_o = show_read;
   assign disp_value_o = disp_value;
   assign disp_count_o = count;
   assign seq_empty_o = seq_empty;

   // modulus of the current digit count, for the range check
   wire [VAL_W:0] mod_lim = pow10(eff_digits_i);

   sequence s_bad_first;
      read_valid_i && is_empty && !digits_ok && !ext.preset_p;
   endsequence

   AST_FIRST_OK: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (read_valid_i && is_empty && digits_ok && !ext.preset_p) |=>
      outputs_o[OUT_OK_BIT] && !seq_empty_o)
      else $error("first valid read not accepted");
   AST_BAD_FIRST: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      s_bad_first |=> outputs_o[OUT_NG_BIT] && seq_empty_o)
      else $error("bad first read stored");
   AST_MATCH: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (read_valid_i && match && !ext.preset_p) |=>
      outputs_o[OUT_OK_BIT] && expected == $past(exp_up))
      else $error("match did not advance");
   AST_MISMATCH: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (rd_ng && !is_empty && !ext.preset_p) |=>
      outputs_o[OUT_NG_BIT] && error_o && $stable(expected))
      else $error("mismatch handling wrong");
   AST_ONLY_OKNG: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      outputs_o[NUM_OUTS-1:2] == '0)
      else $error("unused output driven");
   AST_UPDN_QUIET: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ((ext.up_p || ext.down_p) && !read_valid_i && !ext.enter_p) |=> outputs_o == '0)
      else $error("up or down drove an output");
   AST_PRESET: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ext.preset_p |=> seq_empty_o)
      else $error("preset did not empty");
   AST_COUNT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (read_valid_i && !ext.preset_p) |=> disp_count_o == OUT_CNT_W'($past(count) + 1'b1))
      else $error("counter step wrong");
   AST_WRAP: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !seq_empty_o |-> {1'b0, expected} < mod_lim)
      else $error("expected out of range");
endmodule

// File: rtl/snc_ext_sync.sv
`timescale 1ns/1ps
// two-flop sync plus rising edge detect for the five external inputs
module snc_ext_sync (
   input wire logic clk_i, // system clock
   input wire logic rst_n_i, // async reset, active low
   input wire logic [4:0] pins_i, // 0 enter .. 4 preset
   snc_ext_if.src ext // edge pulses
);
   logic [4:0] meta;
   logic [4:0] sync;
   logic [4:0] last;
   wire [4:0] rise = sync & ~last;

   // synchroniser and edge history
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta <= 5'h00;
         sync <= 5'h00;
         last <= 5'h00;
      end else begin
         meta <= pins_i;
         sync <= meta;
         last <= sync;
      end
   end

   assign ext.enter_p = rise[0];
   assign ext.cancel_p = rise[1];
   assign ext.up_p = rise[2];
   assign ext.down_p = rise[3];
   assign ext.preset_p = rise[4];
endmodule

// File: sim/serial_number_sequence_checker_bench.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) chk(nm, e, g)
module serial_number_sequence_checker_bench;
   import snc_pkg::*;
   logic clk_i, rst_n_i, rv, dir, clr, err, shr, emp;
   logic [63:0] rd;
   logic [5:0] rl;
   logic [4:0] sd, pins;
   logic [2:0] eff;
   logic signed [7:0] inc;
   logic [7:0] outs;
   logic [19:0] dv;
   logic [15:0] dc, c0;
   logic [1:0] r;
   int mismatches, n_compared, cyc;
   snc_reader_model rdr (.clk_i(clk_i), .read_valid_o(rv), .read_data_o(rd), .read_len_o(rl));
   snc_checker #(.NCHARS(8)) dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .read_valid_i(rv),
      .read_data_i(rd), .read_len_i(rl), .dir_reverse_i(dir), .start_digit_i(sd),
      .eff_digits_i(eff), .increment_i(inc), .clear_key_i(clr), .ext_pins_i(pins),
      .outputs_o(outs), .error_o(err), .show_read_o(shr), .disp_value_o(dv),
      .disp_count_o(dc), .seq_empty_o(emp));
   // 100 MHz clock
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   task automatic chk(input string nm, input logic [19:0] e, input logic [19:0] g);
      n_compared++;
      if (g !== e) begin
         $display("[ERR] %s expected %h seen %h", nm, e, g);
         mismatches++;
      end
   endtask
   task automatic print_verdict();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // one read through the reader, result taken the cycle after the strobe
   task automatic rdx(input logic [63:0] s, input logic [5:0] n);
      rdr.send(s, n);
      r = outs[1:0];
   endtask
   // pulse one external input, collecting any result pulse meanwhile
   task automatic ext(input int b);
      r = 2'b00;
      @(negedge clk_i);
      pins[b] = 1'b1;
      repeat (8) begin
         @(negedge clk_i);
         r |= outs[1:0];
      end
      pins[b] = 1'b0;
      @(negedge clk_i);
   endtask
   // unused parallel outputs stay quiet
   always @(negedge clk_i) begin
      if (rst_n_i) `CHK("spare outputs", 20'h0, outs[7:2]);
   end
   // hang guard
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 5000) begin
         mismatches++;
         print_verdict();
      end
   end
   initial begin
      {rst_n_i, dir, clr, pins} = '0;
      sd = 5'h02;
      eff = 3'h3;
      inc = 8'sh03;
      repeat (4) @(negedge clk_i);
      rst_n_i = 1'b1;
      `CHK("empty at start", 20'h1, emp);
      `CHK("count at start", 20'h0, dc);
      rdx("2A1K", 6'h04);
      `CHK("bad digit", 20'h2, r);
      `CHK("bad not stored", 20'h1, emp);
      rdx("100K", 6'h04);
      `CHK("first read", 20'h1, r);
      `CHK("not empty", 20'h0, emp);
      `CHK("next shown", 20'h4, dv);
      c0 = dc;
      rdx("400K", 6'h04);
      `CHK("match", 20'h1, r);
      `CHK("advance", 20'h7, dv);
      `CHK("count", c0 + 16'h1, dc);
      `CHK("no read shown", 20'h0, shr);
      $display("test start and match done");
      rdx("999K", 6'h04);
      `CHK("mismatch", 20'h2, r);
      `CHK("error on", 20'h1, err);
      `CHK("read shown", 20'h1, shr);
      `CHK("read value", 20'h003e7, dv);
      @(negedge clk_i) clr = 1'b1;
      @(negedge clk_i) clr = 1'b0;
      `CHK("error cleared", 20'h0, err);
      `CHK("read hidden", 20'h0, shr);
      `CHK("expected shown", 20'h7, dv);
      rdx("700K", 6'h04);
      `CHK("recover", 20'h1, r);
      `CHK("after recover", 20'h0000a, dv);
      $display("test error and clear done");
      ext(2);
      `CHK("up silent", 20'h0, r);
      `CHK("up value", 20'h0000d, dv);
      ext(2);
      ext(3);
      `CHK("down silent", 20'h0, r);
      `CHK("down value", 20'h0000d, dv);
      rdx("310K", 6'h04);
      `CHK("up up down", 20'h1, r);
      ext(0);
      `CHK("enter ok", 20'h1, r);
      `CHK("enter value", 20'h00013, dv);
      rdx("910K", 6'h04);
      `CHK("enter advanced", 20'h1, r);
      ext(1);
      `CHK("cancel silent", 20'h0, r);
      `CHK("cancel value", 20'h00001, dv);
      rdx("100K", 6'h04);
      `CHK("cancel restart", 20'h1, r);
      $display("test commands done");
      inc = -8'sd5;
      rdx("400K", 6'h04);
      `CHK("negative step", 20'h1, r);
      `CHK("wrap below zero", 20'h003e7, dv);
      ext(4);
      `CHK("preset empties", 20'h1, emp);
      dir = 1'b1;
      rdx("3005K", 6'h05);
      `CHK("tail start", 20'h1, r);
      `CHK("tail digits", 20'h001ef, dv);
      `CHK("total count", 20'h0000b, dc);
      ext(4);
      eff = 3'h1;
      inc = 8'sd127;
      rdx("3005K", 6'h05);
      `CHK("one digit start", 20'h1, r);
      `CHK("one digit wrap", 20'h00007, dv);
      rdx("3705K", 6'h05);
      `CHK("one digit match", 20'h1, r);
      `CHK("one digit next", 20'h00004, dv);
      $display("test wrap preset reverse done");
      print_verdict();
   end
endmodule

// File: sim/snc_reader_model.sv
`timescale 1ns/1ps
// bar code reader: one-cycle read strobe, inverted data once the strobe drops
module snc_reader_model (
   input wire logic clk_i, // system clock
   output logic read_valid_o, // read strobe
   output logic [63:0] read_data_o, // chars, index 0 in low byte
   output logic [5:0] read_len_o // chars in read
);
   // idle values before the first read
   initial begin
      read_valid_o = 1'b0;
      read_data_o = 64'h0;
      read_len_o = 6'h00;
   end
   // present one read for exactly one clock, then scramble the lines
   task automatic send(input logic [63:0] s, input logic [5:0] n);
      @(negedge clk_i);
      read_valid_o <= 1'b1;
      read_data_o <= s;
      read_len_o <= n;
      @(negedge clk_i);
      read_valid_o <= 1'b0;
      read_data_o <= ~s;
      read_len_o <= ~n;
   endtask
endmodule
